// [hw/cnc_node.sv]
// node logic: address and bit-rate selection, positioning sequencer,
// indicators, heartbeat, emergency pacing and communication objects
// assumes a protocol engine outside that frames messages and serves the
// object port, and a motor loop that pulses i_at_target on arrival
// Operation
// - address from tens and ones rotary switches
// - switches 00/01: address from object 2026
// - factory 00 without bus value: address 1
// - switches above 01: switch address, bus ignored
// - slide switch decodes bit rate or bus
// - loop mode, larger target: forward directly
// - loop mode, smaller target: overshoot 5/8, forward
// - loop after non-loop reverse: back off, forward
// - multiturn: mismatch sets status bit 9
// - non-loop mode: straight to target, either way
// - one SDO pair, two PDOs enabled
// - heartbeat every 500 ms by default
// - run indicator follows node state
// - fault indicator patterns by error kind
// - device type object reads zero
// - fault summary bits 0 and 4
// - two latest emergency codes kept
// - sync identifier writable, resets to 80h
// - emergency identifier 80h plus address
// - emergency holdoff spaces emergency sends
`timescale 1ns/1ps
module cnc_node #(
  parameter int REV_COUNTS = 1000, // position counts per output rotation
  parameter int LED_CYC = cnc_pkg::LED_PHASE_CYC, // cycles per flash phase
  parameter int MS_TICK_CYC = cnc_pkg::MS_CYC, // cycles per millisecond
  parameter int HOLD_TICK_CYC = cnc_pkg::HOLDOFF_UNIT_CYC // cycles per holdoff unit
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [3:0] i_addr_tens,
  input wire logic [3:0] i_addr_ones,
  input wire logic [1:0] i_baud_sw,
  input wire logic i_od_req,
  input wire logic i_od_we,
  input wire logic [15:0] i_od_index,
  input wire logic [7:0] i_od_sub,
  input wire logic [31:0] i_od_wdata,
  input wire logic i_move_start,
  input wire logic i_loop_mode,
  input wire logic signed [31:0] i_target,
  input wire logic signed [31:0] i_cur_pos,
  input wire logic i_at_target,
  input wire logic i_multiturn,
  input wire logic signed [31:0] i_abs_pos,
  input wire cnc_pkg::cnc_nmt_t i_nmt_state,
  input wire logic i_warn_limit,
  input wire logic i_guard_event,
  input wire logic i_sync_loss,
  input wire logic i_bus_off,
  input wire logic i_motor_pwr,
  input wire logic i_emcy_event,
  input wire logic [15:0] i_emcy_code,
  output logic o_od_ack,
  output logic o_od_err,
  output logic [31:0] o_od_rdata,
  output logic [6:0] o_node_addr,
  output cnc_pkg::cnc_rate_t o_bit_rate,
  output logic o_drive_req,
  output logic o_drive_fwd,
  output logic signed [31:0] o_drive_target,
  output logic o_busy,
  output logic [15:0] o_status_word,
  output logic o_pdo_tx_en,
  output logic o_pdo_rx_en,
  output logic o_heartbeat,
  output logic o_emcy_send,
  output logic [15:0] o_emcy_code,
  output logic o_run_indicator,
  output logic o_fault_indicator,
  output logic o_motor_indicator
);
  import cnc_pkg::*;

  localparam logic signed [31:0] BACKOFF = 32'(REV_COUNTS * BACKOFF_NUM / BACKOFF_DEN);

  // whole state of the node
  typedef struct packed {
    logic [6:0] node_addr; // active address
    logic [6:0] bus_addr; // address set over the bus
    cnc_rate_t rate; // active bit rate
    cnc_rate_t bus_rate; // bit rate set over the bus
    logic [31:0] sync_identifier;
    logic [31:0] cyc_per;
    logic [31:0] win_len;
    logic [15:0] guard;
    logic [7:0] life;
    logic [15:0] hb_ms;
    logic [15:0] holdoff;
    logic [15:0] hist1; // newest emergency code
    logic [15:0] hist2; // one before
    logic tx_en;
    logic rx_en;
    logic enc_err;
    cnc_mv_t mv;
    logic drv_req; // a leg is running
    logic busy; // sequencer not idle
    logic signed [31:0] drv_tgt; // leg target given to the motor loop
    logic signed [31:0] final_tgt; // end point of the whole move
    logic fwd;
    logic last_rev; // previous move ended in reverse
    logic [31:0] ms_cnt;
    logic [15:0] hb_cnt;
    logic hb;
    logic [31:0] ph_cnt;
    logic [3:0] ph;
    logic run_indicator;
    logic fault_led;
    logic mot_led;
    logic [31:0] ho_cnt;
    logic [15:0] ho_left;
    logic emcy_pend;
    logic emcy;
    logic ack;
    logic err;
    logic [31:0] rdata;
  } cnc_state_t;

  cnc_state_t st_r; // registered state
  cnc_state_t st_nxt; // next state
  logic [6:0] sw_val; // decimal switch value
  logic sw_locked; // switches own the address
  logic comm_err; // any communication fault

  // decimal value of the two rotary digits
  function automatic logic [6:0] dec2(input logic [3:0] t, input logic [3:0] o);
    dec2 = 7'({3'h0, t} * 7'h0A + {3'h0, o});
  endfunction

  // signed position of a leg offset by the backoff distance
  function automatic logic signed [31:0] back_of(input logic signed [31:0] p);
    back_of = p - BACKOFF;
  endfunction

  assign sw_val = dec2(i_addr_tens, i_addr_ones);
  assign sw_locked = sw_val > ADDR_SW_MAX_BUS;
  assign comm_err = i_warn_limit | i_guard_event | i_sync_loss | i_bus_off;

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.hb = 1'b0;
    st_nxt.emcy = 1'b0;
    st_nxt.ack = 1'b0;
    st_nxt.err = 1'b0;
    // address: switches win above 01, else bus value
    st_nxt.node_addr = sw_locked ? sw_val : st_r.bus_addr;
    // bit rate from slide switch, both off means bus value
    unique case (i_baud_sw)
      2'b01: st_nxt.rate = CNC_RATE_250;
      2'b10: st_nxt.rate = CNC_RATE_500;
      2'b11: st_nxt.rate = CNC_RATE_125;
      2'b00: st_nxt.rate = st_r.bus_rate;
    endcase
    // object port: one access per request, answered next cycle
    if (i_od_req) begin
      st_nxt.ack = 1'b1;
      st_nxt.rdata = 32'h0;
      unique case (i_od_index)
        IDX_DEV_TYPE: st_nxt.err = i_od_we;
        IDX_FAULT_SUM: begin
          st_nxt.err = i_od_we;
          st_nxt.rdata[FS_GENERAL_BIT] = comm_err | st_r.enc_err;
          st_nxt.rdata[FS_COMM_BIT] = comm_err;
        end
        IDX_HISTORY: begin
          st_nxt.err = i_od_we;
          if (i_od_sub == 8'h00) begin
            st_nxt.rdata = HIST_DEPTH;
          end else if (i_od_sub == 8'h01) begin
            st_nxt.rdata = {16'h0, st_r.hist1};
          end else if (i_od_sub == 8'h02) begin
            st_nxt.rdata = {16'h0, st_r.hist2};
          end else begin
            st_nxt.err = 1'b1;
          end
        end
        IDX_SYNC_IDENTIFIER: begin
          st_nxt.rdata = st_r.sync_identifier;
          if (i_od_we) st_nxt.sync_identifier = i_od_wdata;
        end
        IDX_CYC_PER: begin
          st_nxt.rdata = st_r.cyc_per;
          if (i_od_we) st_nxt.cyc_per = i_od_wdata;
        end
        IDX_WIN_LEN: begin
          st_nxt.rdata = st_r.win_len;
          if (i_od_we) st_nxt.win_len = i_od_wdata;
        end
        IDX_GUARD: begin
          st_nxt.rdata = {16'h0, st_r.guard};
          if (i_od_we) st_nxt.guard = i_od_wdata[15:0];
        end
        IDX_LIFE: begin
          st_nxt.rdata = {24'h0, st_r.life};
          if (i_od_we) st_nxt.life = i_od_wdata[7:0];
        end
        IDX_EMERGENCY_IDENTIFIER: begin
          st_nxt.err = i_od_we;
          st_nxt.rdata = EMCY_BASE + {25'h0, st_r.node_addr};
        end
        IDX_HOLDOFF: begin
          st_nxt.rdata = {16'h0, st_r.holdoff};
          if (i_od_we) st_nxt.holdoff = i_od_wdata[15:0];
        end
        IDX_HEARTBEAT: begin
          st_nxt.rdata = {16'h0, st_r.hb_ms};
          if (i_od_we) st_nxt.hb_ms = i_od_wdata[15:0];
        end
        IDX_SDO: begin
          st_nxt.err = i_od_we;
          // sub 1 receive channel, sub 2 transmit channel
          st_nxt.rdata = (i_od_sub == 8'h02) ? SDO_TX_BASE + {25'h0, st_r.node_addr}
                                             : SDO_RX_BASE + {25'h0, st_r.node_addr};
        end
        IDX_RPDO: begin
          st_nxt.rdata = RPDO_BASE + {25'h0, st_r.node_addr};
          st_nxt.rdata[COB_INVALID_BIT] = ~st_r.rx_en;
          if (i_od_we) st_nxt.rx_en = ~i_od_wdata[COB_INVALID_BIT];
        end
        IDX_TPDO: begin
          st_nxt.rdata = TPDO_BASE + {25'h0, st_r.node_addr};
          st_nxt.rdata[COB_INVALID_BIT] = ~st_r.tx_en;
          if (i_od_we) st_nxt.tx_en = ~i_od_wdata[COB_INVALID_BIT];
        end
        IDX_STATUS: begin
          st_nxt.err = i_od_we;
          st_nxt.rdata[ST_ENC_ERR_BIT] = st_r.enc_err;
        end
        IDX_NODE_ADDR: begin
          st_nxt.rdata = {25'h0, st_r.node_addr};
          // refused while the switches hold the address
          if (i_od_we && sw_locked) begin
            st_nxt.err = 1'b1;
          end else if (i_od_we) begin
            st_nxt.bus_addr = i_od_wdata[6:0];
          end
        end
        IDX_BUS_BAUD: begin
          st_nxt.rdata = {30'h0, st_r.bus_rate};
          if (i_od_we) st_nxt.bus_rate = cnc_rate_t'(i_od_wdata[1:0]);
        end
        default: st_nxt.err = 1'b1; // unknown object
      endcase
    end
    // positioning sequencer
    unique case (st_r.mv)
      CNC_MV_IDLE: begin
        if (i_move_start) begin
          st_nxt.final_tgt = i_target;
          st_nxt.enc_err = 1'b0;
          if (!i_loop_mode) begin
            // direct move either way
            st_nxt.mv = CNC_MV_APPR;
            st_nxt.drv_tgt = i_target;
            st_nxt.fwd = i_target >= i_cur_pos;
            st_nxt.last_rev = i_target < i_cur_pos;
          end else if (i_target < i_cur_pos) begin
            // overshoot below target, then come back forward
            st_nxt.mv = CNC_MV_BACK;
            st_nxt.drv_tgt = back_of(i_target);
            st_nxt.fwd = 1'b0;
          end else if (st_r.last_rev) begin
            // take up play left by an earlier reverse run
            st_nxt.mv = CNC_MV_BACK;
            st_nxt.drv_tgt = back_of(i_cur_pos);
            st_nxt.fwd = 1'b0;
          end else begin
            st_nxt.mv = CNC_MV_APPR;
            st_nxt.drv_tgt = i_target;
            st_nxt.fwd = 1'b1;
          end
        end
      end
      CNC_MV_BACK: begin
        // reverse leg done, final leg always forward
        if (i_at_target) begin
          st_nxt.mv = CNC_MV_APPR;
          st_nxt.drv_tgt = st_r.final_tgt;
          st_nxt.fwd = 1'b1;
          st_nxt.last_rev = 1'b0;
        end
      end
      CNC_MV_APPR: begin
        if (i_at_target) begin
          st_nxt.mv = i_multiturn ? CNC_MV_CHECK : CNC_MV_IDLE;
        end
      end
      CNC_MV_CHECK: begin
        // compare reached position with absolute encoder
        if (i_abs_pos != st_r.final_tgt) st_nxt.enc_err = 1'b1;
        st_nxt.mv = CNC_MV_IDLE;
      end
    endcase
    // leg and busy flags registered so the outputs come from flops
    st_nxt.drv_req = st_nxt.mv == CNC_MV_BACK || st_nxt.mv == CNC_MV_APPR;
    st_nxt.busy = st_nxt.mv != CNC_MV_IDLE;
    // heartbeat: millisecond ticks counted against the interval
    if (st_r.ms_cnt == 32'(MS_TICK_CYC - 1)) begin
      st_nxt.ms_cnt = 32'h0;
      if (st_r.hb_ms == 16'h0) begin
        st_nxt.hb_cnt = 16'h0;
      end else if (st_r.hb_cnt + 16'h1 >= st_r.hb_ms) begin
        st_nxt.hb_cnt = 16'h0;
        st_nxt.hb = 1'b1;
      end else begin
        st_nxt.hb_cnt = st_r.hb_cnt + 16'h1;
      end
    end else begin
      st_nxt.ms_cnt = st_r.ms_cnt + 32'h1;
    end
    // indicator phases, ten per pattern
    if (st_r.ph_cnt == 32'(LED_CYC - 1)) begin
      st_nxt.ph_cnt = 32'h0;
      st_nxt.ph = (st_r.ph == LED_LAST_PHASE) ? 4'h0 : st_r.ph + 4'h1;
    end else begin
      st_nxt.ph_cnt = st_r.ph_cnt + 32'h1;
    end
    // run indicator by node state
    unique case (i_nmt_state)
      CNC_NMT_STOPPED: st_nxt.run_indicator = st_r.ph == 4'h0;
      CNC_NMT_PREOP: st_nxt.run_indicator = ~st_r.ph[0];
      CNC_NMT_OPER: st_nxt.run_indicator = 1'b1;
      CNC_NMT_INIT: st_nxt.run_indicator = 1'b0;
    endcase
    // fault indicator, most severe error first
    if (i_bus_off) begin
      st_nxt.fault_led = 1'b1;
    end else if (i_sync_loss) begin
      st_nxt.fault_led = st_r.ph == 4'h0 || st_r.ph == 4'h2 || st_r.ph == 4'h4;
    end else if (i_guard_event) begin
      st_nxt.fault_led = st_r.ph == 4'h0 || st_r.ph == 4'h2;
    end else if (i_warn_limit) begin
      st_nxt.fault_led = st_r.ph == 4'h0;
    end else begin
      st_nxt.fault_led = 1'b0;
    end
    st_nxt.mot_led = i_motor_pwr;
    // emergency: history shift and paced sending
    if (st_r.ho_cnt == 32'(HOLD_TICK_CYC - 1)) begin
      st_nxt.ho_cnt = 32'h0;
      if (st_r.ho_left != 16'h0) st_nxt.ho_left = st_r.ho_left - 16'h1;
    end else begin
      st_nxt.ho_cnt = st_r.ho_cnt + 32'h1;
    end
    if (st_r.emcy_pend && st_r.ho_left == 16'h0) begin
      st_nxt.emcy = 1'b1;
      st_nxt.emcy_pend = 1'b0;
      st_nxt.ho_left = st_r.holdoff;
    end
    // a new event is never lost, even while the pending flag clears
    if (i_emcy_event) begin
      st_nxt.hist1 = i_emcy_code;
      st_nxt.hist2 = st_r.hist1;
      st_nxt.emcy_pend = 1'b1;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_r <= '0;
      st_r.node_addr <= ADDR_RST;
      st_r.bus_addr <= ADDR_RST;
      st_r.rate <= BUS_RATE_RST;
      st_r.bus_rate <= BUS_RATE_RST;
      st_r.sync_identifier <= SYNC_IDENTIFIER_RST;
      st_r.hb_ms <= HB_RST_MS;
      st_r.tx_en <= 1'b1;
      st_r.rx_en <= 1'b1;
      st_r.mv <= CNC_MV_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign o_od_ack = st_r.ack;
  assign o_od_err = st_r.err;
  assign o_od_rdata = st_r.rdata;
  assign o_node_addr = st_r.node_addr;
  assign o_bit_rate = st_r.rate;
  assign o_drive_req = st_r.drv_req;
  assign o_drive_fwd = st_r.fwd;
  assign o_drive_target = st_r.drv_tgt;
  assign o_busy = st_r.busy;
  assign o_status_word = {6'h0, st_r.enc_err, 9'h0};
  assign o_pdo_tx_en = st_r.tx_en;
  assign o_pdo_rx_en = st_r.rx_en;
  assign o_heartbeat = st_r.hb;
  assign o_emcy_send = st_r.emcy;
  assign o_emcy_code = st_r.hist1;
  assign o_run_indicator = st_r.run_indicator;
  assign o_fault_indicator = st_r.fault_led;
  assign o_motor_indicator = st_r.mot_led;

  // reverse leg finished while a loop move is running
  sequence s_back_done;
    st_r.mv == CNC_MV_BACK && i_at_target;
  endsequence
  // loop move below current position is accepted
  sequence s_loop_down;
    st_r.mv == CNC_MV_IDLE && i_move_start && i_loop_mode && i_target < i_cur_pos;
  endsequence

  a_switch_addr: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    sw_locked |=> o_node_addr == $past(sw_val)) else $error("switch address not taken");
  a_addr_refused: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_od_req && i_od_we && i_od_index == IDX_NODE_ADDR && sw_locked
    |=> o_od_err && st_r.bus_addr == $past(st_r.bus_addr)) else $error("address write accepted");
  a_rate_both_on: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_baud_sw == 2'b11 |=> o_bit_rate == CNC_RATE_125) else $error("wrong bit rate");
  a_loop_overshoot: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    s_loop_down |=> !o_drive_fwd && o_drive_req
    && o_drive_target == $past(i_target) - BACKOFF) else $error("no overshoot leg");
  a_forward_finish: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    s_back_done |=> o_drive_fwd && o_drive_target == st_r.final_tgt) else $error("not forward");
  a_direct_move: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    st_r.mv == CNC_MV_IDLE && i_move_start && !i_loop_mode
    |=> st_r.mv == CNC_MV_APPR && o_drive_target == $past(i_target)) else $error("not direct");
  a_encoder_check: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    st_r.mv == CNC_MV_CHECK && i_abs_pos != st_r.final_tgt
    |=> o_status_word[ST_ENC_ERR_BIT]) else $error("encoder error not flagged");
  a_run_oper: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_nmt_state == CNC_NMT_OPER [*2] |-> o_run_indicator) else $error("run indicator off");
  a_bus_off_led: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_bus_off |=> o_fault_indicator) else $error("fault indicator off");
  a_motor_led: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    ##1 o_motor_indicator == $past(i_motor_pwr)) else $error("motor indicator wrong");
  a_emcy_ident: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_od_req && !i_od_we && i_od_index == IDX_EMERGENCY_IDENTIFIER
    |=> o_od_rdata == EMCY_BASE + {25'h0, $past(st_r.node_addr)}) else $error("bad emergency_identifier");
  a_dev_type_zero: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_od_req && i_od_index == IDX_DEV_TYPE |=> o_od_ack && o_od_rdata == 32'h0)
    else $error("device type not zero");
  a_holdoff_gap: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_emcy_send && st_r.ho_left != 16'h0 |=> !o_emcy_send) else $error("emergencies back to back");
endmodule

// [hw/cnc_pkg.sv]
// constants, types and object indices shared by the node logic
// assumes one 125 MHz system clock; all times are turned into cycles here
package cnc_pkg;
  // clock rate
  localparam int CLK_MHZ = 125;
  // indicator flash phase length and its cycle count
  localparam int LED_PHASE_MS = 200;
  localparam int LED_PHASE_CYC = LED_PHASE_MS * 1000 * CLK_MHZ;
  // millisecond tick for the heartbeat
  localparam int MS_US = 1000;
  localparam int MS_CYC = MS_US * CLK_MHZ;
  // emergency holdoff unit (100 us) and its cycle count
  localparam int HOLDOFF_UNIT_US = 100;
  localparam int HOLDOFF_UNIT_CYC = HOLDOFF_UNIT_US * CLK_MHZ;
  // last indicator phase of a pattern (ten phases, 0 to 9)
  localparam logic [3:0] LED_LAST_PHASE = 4'h9;
  // backlash removal distance as a fraction of one rotation
  localparam int BACKOFF_NUM = 5;
  localparam int BACKOFF_DEN = 8;
  // object indices
  localparam logic [15:0] IDX_DEV_TYPE = 16'h1000;
  localparam logic [15:0] IDX_FAULT_SUM = 16'h1001;
  localparam logic [15:0] IDX_HISTORY = 16'h1003;
  localparam logic [15:0] IDX_SYNC_IDENTIFIER = 16'h1005;
  localparam logic [15:0] IDX_CYC_PER = 16'h1006;
  localparam logic [15:0] IDX_WIN_LEN = 16'h1007;
  localparam logic [15:0] IDX_GUARD = 16'h100C;
  localparam logic [15:0] IDX_LIFE = 16'h100D;
  localparam logic [15:0] IDX_EMERGENCY_IDENTIFIER = 16'h1014;
  localparam logic [15:0] IDX_HOLDOFF = 16'h1015;
  localparam logic [15:0] IDX_HEARTBEAT = 16'h1017;
  localparam logic [15:0] IDX_SDO = 16'h1200;
  localparam logic [15:0] IDX_RPDO = 16'h1400;
  localparam logic [15:0] IDX_TPDO = 16'h1800;
  localparam logic [15:0] IDX_STATUS = 16'h2020;
  localparam logic [15:0] IDX_NODE_ADDR = 16'h2026;
  localparam logic [15:0] IDX_BUS_BAUD = 16'h2027;
  // reset values and identifier bases
  localparam logic [31:0] SYNC_IDENTIFIER_RST = 32'h0000_0080;
  localparam logic [31:0] EMCY_BASE = 32'h0000_0080;
  localparam logic [31:0] RPDO_BASE = 32'h0000_0200;
  localparam logic [31:0] TPDO_BASE = 32'h0000_0180;
  localparam logic [31:0] SDO_RX_BASE = 32'h0000_0600;
  localparam logic [31:0] SDO_TX_BASE = 32'h0000_0580;
  localparam logic [15:0] HB_RST_MS = 16'h01F4;
  localparam logic [6:0] ADDR_RST = 7'h01;
  localparam logic [6:0] ADDR_SW_MAX_BUS = 7'h01;
  localparam logic [31:0] HIST_DEPTH = 32'h0000_0002;
  // field positions
  localparam int ST_ENC_ERR_BIT = 9;
  localparam int FS_GENERAL_BIT = 0;
  localparam int FS_COMM_BIT = 4;
  localparam int COB_INVALID_BIT = 31;
  // bit rates
  typedef enum logic [1:0] {CNC_RATE_125, CNC_RATE_250, CNC_RATE_500, CNC_RATE_1000} cnc_rate_t;
  localparam cnc_rate_t BUS_RATE_RST = CNC_RATE_250;
  // node states reported by the protocol engine
  typedef enum logic [1:0] {CNC_NMT_INIT, CNC_NMT_STOPPED, CNC_NMT_PREOP, CNC_NMT_OPER} cnc_nmt_t;
  // positioning sequencer
  typedef enum logic [1:0] {CNC_MV_IDLE, CNC_MV_BACK, CNC_MV_APPR, CNC_MV_CHECK} cnc_mv_t;
endpackage

// [sim/cnc_motor_model.sv]
// motor loop stand-in: runs each leg the node asks for and reports arrival
// assumes the node holds a leg steady until arrival is reported
`timescale 1ns/1ps
module cnc_motor_model #(
  parameter int DLY = 3 // prompt arrival delay in cycles
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_slow,
  input wire logic i_drive_req,
  input wire logic signed [31:0] i_drive_target,
  output logic o_at_target,
  output logic signed [31:0] o_cur_pos
);
  logic [5:0] cnt_r; // cycles spent on this leg
  logic signed [31:0] leg_r; // end point of the leg in work
  logic done_r; // arrival already reported
  // count out the leg, then land on its end and pulse arrival once
  // no target is placed at a mechanical stop, so no block run is started
  always @(posedge i_sys_clk) begin
    o_at_target <= 1'b0;
    if (i_reset || !i_drive_req || i_drive_target != leg_r) begin
      cnt_r <= 6'h00;
      done_r <= 1'b0;
      leg_r <= i_drive_target;
      if (i_reset) o_cur_pos <= 32'sh0;
    end else if (!done_r && cnt_r == (i_slow ? 6'h20 : 6'(DLY))) begin
      o_at_target <= 1'b1;
      o_cur_pos <= i_drive_target;
      done_r <= 1'b1;
    end else if (!done_r) cnt_r <= cnt_r + 6'h01;
  end
endmodule

// [sim/tb_top.sv]
// self-checking bench for the node logic: objects, address, rate, moves,
// indicators, emergencies and heartbeat; needs cnc_pkg and the motor stand-in
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("Error %s exp %0h got %0h", n, e, a); end end
module tb_top;
  import cnc_pkg::*;
  localparam int BO = 1000 * BACKOFF_NUM / BACKOFF_DEN; // back-off distance
  logic i_sys_clk = 1'b0, i_reset = 1'b1, i_od_req = 1'b0, i_od_we = 1'b0, i_move_start = 1'b0;
  logic i_loop_mode = 1'b0, i_multiturn = 1'b1, i_motor_pwr = 1'b0, i_emcy_event = 1'b0;
  logic i_warn_limit = 1'b0, i_guard_event = 1'b0, i_sync_loss = 1'b0, i_bus_off = 1'b0;
  logic [3:0] i_addr_tens = 4'h0, i_addr_ones = 4'h0;
  logic [1:0] i_baud_sw = 2'h0;
  logic [15:0] i_od_index = 16'h0, i_emcy_code = 16'h0, o_status_word, o_emcy_code;
  logic [7:0] i_od_sub = 8'h0;
  logic [31:0] i_od_wdata = 32'h0, o_od_rdata, v, w;
  logic signed [31:0] i_target = 32'sh0, i_abs_pos, i_cur_pos, o_drive_target, abs_off = 32'sh0;
  cnc_nmt_t i_nmt_state = CNC_NMT_INIT;
  logic i_at_target, o_od_ack, o_od_err, o_drive_req, o_drive_fwd, o_busy, o_pdo_tx_en, slow;
  logic o_pdo_rx_en, o_heartbeat, o_emcy_send, o_run_indicator, o_fault_indicator;
  logic o_motor_indicator, rev_nl = 1'b0;
  logic [6:0] o_node_addr;
  cnc_rate_t o_bit_rate;
  logic [32:0] legs[$], exp_l[$], key_d = 33'h0; // legs seen, legs expected
  int bad_count = 0, checks_done = 0, cyc = 0, i, n, pos = 0, ro, fo;
  logic [1:0] nmt_tab [5] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h3};
  int run_on [5] = '{4, 4, 20, 40, 40};
  int flt_on [5] = '{0, 4, 8, 12, 40};
  integer seed = 93;
  assign i_abs_pos = i_cur_pos + abs_off;
  initial slow = 1'b0;
  always #4 i_sys_clk = ~i_sys_clk;
  cnc_node #(.LED_CYC(4), .MS_TICK_CYC(4), .HOLD_TICK_CYC(2)) dut (.*);
  cnc_motor_model u_motor (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_slow(slow),
    .i_drive_req(o_drive_req), .i_drive_target(o_drive_target), .o_at_target(i_at_target),
    .o_cur_pos(i_cur_pos));
  // log each new leg; cut a hung run short
  always @(posedge i_sys_clk) begin
    if (o_drive_req && {o_drive_req, o_drive_target} != key_d)
      legs.push_back({o_drive_fwd, o_drive_target});
    key_d <= {o_drive_req, o_drive_target};
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask
  // one object access, answer one cycle later
  task automatic od(input logic we, input logic [15:0] idx, input logic [7:0] sb,
                    input logic [31:0] wd);
    tick(1);
    {i_od_req, i_od_we, i_od_index, i_od_sub, i_od_wdata} = {1'b1, we, idx, sb, wd};
    tick(1);
    i_od_req = 1'b0;
    `CHK("ack", 1'b1, o_od_ack)
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] wd, input logic e);
    od(1'b1, idx, 8'h0, wd);
    `CHK("err", e, o_od_err)
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] e);
    od(1'b0, idx, sb, 32'h0);
    `CHK("rdata", e, o_od_rdata)
  endtask
  function automatic cnc_rate_t exp_rate(input logic [1:0] sw);
    cnc_rate_t t [4] = '{CNC_RATE_1000, CNC_RATE_250, CNC_RATE_500, CNC_RATE_125};
    return t[sw];
  endfunction
  // start a move, wait it out, compare legs and encoder flag
  task automatic mv(input logic lp, input int tgt, input logic bad);
    exp_l.delete();
    if (!lp) exp_l.push_back({tgt > pos, 32'(tgt)});
    else if (rev_nl || tgt < pos) begin
      exp_l.push_back({1'b0, 32'(rev_nl ? pos - BO : tgt - BO)});
      exp_l.push_back({1'b1, 32'(tgt)});
    end else exp_l.push_back({1'b1, 32'(tgt)});
    rev_nl = !lp && tgt < pos;
    pos = tgt;
    abs_off = bad ? 32'sh1 : 32'sh0;
    legs.delete();
    tick(1);
    {i_move_start, i_loop_mode, i_target} = {1'b1, lp, 32'(tgt)};
    tick(1);
    i_move_start = 1'b0;
    for (n = 0; o_busy === 1'b1 && n < 500; n++) tick(1);
    `CHK("legs", exp_l.size(), legs.size())
    foreach (exp_l[k]) if (k < legs.size()) `CHK("leg", exp_l[k], legs[k])
    `CHK("enc_err", bad & i_multiturn, o_status_word[9])
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    tick(12);
    i_reset = 1'b0;
    tick(3);
    `CHK("addr", 7'h01, o_node_addr)
    `CHK("pdo_en", 2'b11, {o_pdo_tx_en, o_pdo_rx_en})
    `CHK("motor", 1'b0, o_motor_indicator)
    rd(IDX_DEV_TYPE, 8'h0, 32'h0);
    rd(IDX_SYNC_IDENTIFIER, 8'h0, 32'h80);
    rd(IDX_HOLDOFF, 8'h0, 32'h0);
    wr(IDX_DEV_TYPE, 32'h5, 1'b1);
    for (i = 0; i < 3; i++) begin
      v = $random(seed);
      wr(IDX_SYNC_IDENTIFIER, v, 1'b0);
      rd(IDX_SYNC_IDENTIFIER, 8'h0, v);
      wr(IDX_HOLDOFF, v, 1'b0);
      rd(IDX_HOLDOFF, 8'h0, {16'h0, v[15:0]});
    end
    wr(IDX_HOLDOFF, 32'h1, 1'b0);
    v = 32'(2 + {$random(seed)} % 60);
    wr(IDX_NODE_ADDR, v, 1'b0);
    tick(3);
    `CHK("addr", v[6:0], o_node_addr)
    rd(IDX_EMERGENCY_IDENTIFIER, 8'h0, 32'h80 + v);
    {i_addr_tens, i_addr_ones} = 8'h42;
    tick(3);
    `CHK("addr", 7'h2A, o_node_addr)
    wr(IDX_NODE_ADDR, 32'h9, 1'b1);
    tick(3);
    `CHK("addr", 7'h2A, o_node_addr)
    rd(IDX_EMERGENCY_IDENTIFIER, 8'h0, 32'hAA);
    {i_addr_tens, i_addr_ones} = 8'h01;
    tick(3);
    `CHK("addr", v[6:0], o_node_addr)
    wr(IDX_BUS_BAUD, 32'h3, 1'b0);
    for (i = 0; i < 4; i++) begin
      i_baud_sw = 2'(i);
      tick(3);
      `CHK("rate", exp_rate(2'(i)), o_bit_rate)
    end
    mv(1'b1, 3000, 1'b0);
    slow = 1'b1;
    mv(1'b1, 1000, 1'b0);
    {slow, i_multiturn} = 2'b00;
    mv(1'b0, 2500, 1'b0);
    mv(1'b0, 500, 1'b1);
    i_multiturn = 1'b1;
    mv(1'b1, 2000, 1'b1);
    rd(IDX_FAULT_SUM, 8'h0, 32'h1);
    i_motor_pwr = 1'b1;
    tick(2);
    `CHK("motor", 1'b1, o_motor_indicator)
    for (i = 0; i < 5; i++) begin
      i_nmt_state = cnc_nmt_t'(nmt_tab[i]);
      {i_bus_off, i_sync_loss, i_guard_event, i_warn_limit} = 4'((5'h01 << i) >> 1);
      tick(2);
      {ro, fo} = 64'h0;
      repeat (40) begin
        ro += int'(o_run_indicator === 1'b1);
        fo += int'(o_fault_indicator === 1'b1);
        tick(1);
      end
      `CHK("run_indicator", run_on[i], ro)
      `CHK("fault_led", flt_on[i], fo)
    end
    od(1'b0, IDX_FAULT_SUM, 8'h0, 32'h0);
    `CHK("comm_bit", 1'b1, o_od_rdata[4])
    for (i = 0; i < 2; i++) begin
      w = v;
      v = {16'h0, 16'($random(seed))};
      {i_emcy_event, i_emcy_code} = {1'b1, v[15:0]};
      tick(1);
      i_emcy_event = 1'b0;
      `CHK("emcy_code", v[15:0], o_emcy_code)
      tick(1);
      `CHK("emcy_send", 1'b1, o_emcy_send)
      tick(3);
    end
    rd(IDX_HISTORY, 8'h1, v);
    rd(IDX_HISTORY, 8'h2, w);
    for (n = 0; o_heartbeat !== 1'b1 && n < 2100; n++) tick(1);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (o_heartbeat !== 1'b1 && n < 2100);
    `CHK("hb_gap", 2000, n)
    final_report();
  end
endmodule
